// >>> src/toi_consts.svh
// constants for the transmit overhead inserter
`ifndef TOI_CONSTS_SVH
`define TOI_CONSTS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define TOI_CFG_CH1_OFFSET 16'h1080
`define TOI_CFG_CH2_OFFSET 16'h1480
`define TOI_CFG_CH3_OFFSET 16'h1880
`define TOI_CFG_CH4_OFFSET 16'h1C80
`define TOI_AUX_DELTA      16'h0010
`define TOI_STAT_DELTA     16'h0014
`define TOI_CFG_RESET      12'h721
`define TOI_AUX_RESET      1'h1
`define TOI_CFG_WIDTH      12

// ----------------------------------------------------------------
// frame layout and fixed bytes
// ----------------------------------------------------------------
`define TOI_A1_VALUE       8'hF6
`define TOI_A2_VALUE       8'h28
`define TOI_ROWS           9
`define TOI_STS_N          12
`define TOI_TOH_COLS       3
`define TOI_COL_N          1080
`define TOI_Z0_ITU_LAST    3
`define TOI_Z0_WIDE_LAST   11
`define TOI_STS3_N         4
`define TOI_REI_BIT_PER_STS1 8
`define TOI_REI_BLK_PER_STS3 1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TOI_CLK_HZ         100000000
`define TOI_SEC_DCC_HZ     192000
`define TOI_LINE_DCC_HZ    576000

`endif

// >>> src/toi_pkg.sv
// types of the transmit overhead inserter
package toi_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic       sof;
  } toi_byte_s;

  typedef struct packed {
    logic rei_block_mode;
    logic line_rei_insert_enable;
    logic protection_switch_insert_enable;
    logic line_dcc_clock_tristate;
    logic line_dcc_port_enable;
    logic shared_dcc_channel_select;
    logic shared_dcc_clock_tristate;
    logic shared_dcc_port_enable;
    logic trace_insert_enable;
    logic path_number_pattern_enable;
    logic growth_byte_definition;
    logic framing_insert_enable;
  } toi_cfg_s;

  typedef struct packed {
    logic [7:0] k1;
    logic [7:0] k2;
    logic [7:0] rei_count;
  } toi_rx_oh_s;

  typedef enum logic [3:0] {
    TK_PASS, TK_A1, TK_A2, TK_J0, TK_Z0, TK_DSEC, TK_DLINE, TK_K1, TK_K2, TK_M1
  } toi_kind_e;

endpackage : toi_pkg

// >>> src/toi_inserter.sv
// transmit overhead inserter with its input fifo
//
// Contract
// R01 - framing enabled: A1 bytes become F6, A2 bytes become 28; else untouched.
// R02 - narrow growth definition: Z0 in STS-1 #2..#4 master, #1..#4 slave.
// R03 - wide growth definition: Z0 in STS-1 #2..#12 master, #1..#12 slave.
// R04 - software keeps national bytes #5..#12 free of long constant runs.
// R05 - pattern enabled: J0 and Z0 carry their STS-1 path number.
// R06 - trace enabled: trace processor byte goes into J0 of STS-1 #1.
// R07 - shared serial port enabled: its bits fill D1-D3 or D4-D12 of #1.
// R08 - channel select 0 is D1-D3 at 192 kHz, 1 is D4-D12 at 576 kHz.
// R09 - shared port clock tristate bit set: clock output not driven.
// R10 - line serial port enabled: its bits fill D4-D12 of STS-1 #1.
// R11 - line port clock tristate bit set: clock output not driven.
// R12 - APS enabled: received K1/K2 copied into K1/K2 of STS-1 #1.
// R13 - line REI enabled: received REI goes into M1 of STS-1 #3.
// R14 - block mode: M1 counts BIP-24 blocks, one per STS-3 per frame.
// R15 - bit mode: M1 counts BIP-8 bit errors, eight per STS-1 per frame.
// R16 - one fixed priority among sources competing for one byte.
// R17 - framing first, serial and register next, received next, pass last.
`timescale 1ns/100ps
`include "toi_consts.svh"

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module toi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign rd_valid = (cnt_q != '0);
  assign rd_data  = mem[rd_ptr_q];
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_valid && rd_ready;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q    <= '0;
      wr_ready <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      wr_ready <= (cnt_d != DEPTH[AW:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= wr_data;
    end
  end

endmodule : toi_fifo

// ----------------------------------------------------------------
// inserter
// ----------------------------------------------------------------
module toi_inserter import toi_pkg::*; #(
  parameter int CHANNEL    = 1,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire toi_byte_s   in_byte,
  input  wire logic        in_valid,
  output logic             in_ready,
  output toi_byte_s        out_byte,
  output logic             out_valid,
  input  wire logic        out_ready,
  input  wire logic [7:0]  trace_byte,
  input  wire toi_rx_oh_s  rx_oh,
  input  wire logic        shared_dcc_serial_port,
  output logic             shared_dcc_port_clock_o,
  output logic             shared_dcc_port_clock_oe,
  input  wire logic        line_dcc_serial_port,
  output logic             line_dcc_port_clock_o,
  output logic             line_dcc_port_clock_oe
);
  if (CHANNEL < 1 || CHANNEL > 4) begin : g_bad_channel
    $error("channel must be 1 to 4");
  end

  localparam logic [15:0] CFG_ADDR = (CHANNEL == 1) ? `TOI_CFG_CH1_OFFSET :
                                     (CHANNEL == 2) ? `TOI_CFG_CH2_OFFSET :
                                     (CHANNEL == 3) ? `TOI_CFG_CH3_OFFSET :
                                                      `TOI_CFG_CH4_OFFSET;
  localparam int SEC_HALF  = `TOI_CLK_HZ / (2 * `TOI_SEC_DCC_HZ);
  localparam int LINE_HALF = `TOI_CLK_HZ / (2 * `TOI_LINE_DCC_HZ);
  localparam logic [7:0] REI_BIT_MAX = 8'(`TOI_STS_N * `TOI_REI_BIT_PER_STS1);
  localparam logic [7:0] REI_BLK_MAX = 8'(`TOI_STS3_N * `TOI_REI_BLK_PER_STS3);
  localparam logic [10:0] COL_LAST   = 11'(`TOI_COL_N - 1);
  localparam logic [3:0]  ROW_LAST   = 4'(`TOI_ROWS - 1);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] delta);
    reg_hit = (addr == 16'(CFG_ADDR + delta));
  endfunction : reg_hit

  function automatic toi_kind_e toh_kind(input logic [3:0] row, input logic [1:0] tc,
                                         input logic [3:0] sts, input logic master,
                                         input logic narrow);
    logic [3:0] z0_last;
    z0_last  = narrow ? 4'(`TOI_Z0_ITU_LAST) : 4'(`TOI_Z0_WIDE_LAST);
    toh_kind = TK_PASS;
    case (row)
      4'h0: begin
        if (tc == 2'h0) begin
          toh_kind = TK_A1;
        end else if (tc == 2'h1) begin
          toh_kind = TK_A2;
        end else if (sts == 4'h0 && master) begin
          toh_kind = TK_J0;
        // R02 narrow Z0 span
        // R03 wide Z0 span
        end else if (sts <= z0_last) begin
          toh_kind = TK_Z0;
        end
      end
      4'h2: toh_kind = (sts == 4'h0) ? TK_DSEC : TK_PASS;
      4'h4: begin
        if (sts == 4'h0 && tc == 2'h1) begin
          toh_kind = TK_K1;
        end else if (sts == 4'h0 && tc == 2'h2) begin
          toh_kind = TK_K2;
        end
      end
      4'h5, 4'h6, 4'h7: toh_kind = (sts == 4'h0) ? TK_DLINE : TK_PASS;
      4'h8: toh_kind = (sts == 4'h2 && tc == 2'h1) ? TK_M1 : TK_PASS;
      default: toh_kind = TK_PASS;
    endcase
  endfunction : toh_kind

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  toi_cfg_s    cfg_q;
  logic        master_q;
  logic [3:0]  row_q;
  logic [10:0] col_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q    <= toi_cfg_s'(`TOI_CFG_RESET);
      master_q <= `TOI_AUX_RESET;
    end else if (reg_wr) begin
      if (reg_hit(reg_addr, 16'h0000)) begin
        cfg_q <= toi_cfg_s'(reg_wdata[`TOI_CFG_WIDTH-1:0]);
      end
      if (reg_hit(reg_addr, `TOI_AUX_DELTA)) begin
        master_q <= reg_wdata[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && reg_hit(reg_addr, 16'h0000)) begin
      reg_rdata <= {4'h0, cfg_q};
    end else if (reg_rd && reg_hit(reg_addr, `TOI_AUX_DELTA)) begin
      reg_rdata <= {15'h0000, master_q};
    end else if (reg_rd && reg_hit(reg_addr, `TOI_STAT_DELTA)) begin
      reg_rdata <= {1'b0, col_q, row_q};
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // serial dcc ports
  // ----------------------------------------------------------------
  logic [1:0] port_din;
  logic [1:0] port_ts;
  logic [1:0] port_clk;
  logic [7:0] port_byte [2];

  assign port_din = {line_dcc_serial_port, shared_dcc_serial_port};
  assign port_ts  = {cfg_q.line_dcc_clock_tristate, cfg_q.shared_dcc_clock_tristate};

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [9:0] div_q;
    logic [9:0] half;
    logic       clk_q;
    logic       oe_q;
    logic [2:0] sync_q;
    logic       stable_q;
    logic [7:0] shift_q;
    logic [2:0] nbit_q;
    logic [7:0] hold_q;

    // R08 port rate follows channel select
    assign half = (p == 0 && !cfg_q.shared_dcc_channel_select) ?
                  10'(SEC_HALF - 1) : 10'(LINE_HALF - 1);

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        div_q <= 10'h000;
        clk_q <= 1'b0;
      end else if (div_q >= half) begin
        div_q <= 10'h000;
        clk_q <= ~clk_q;
      end else begin
        div_q <= div_q + 10'h001;
      end
    end

    // R09 shared clock drive control
    // R11 line clock drive control
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        oe_q <= 1'b0;
      end else begin
        oe_q <= ~port_ts[p];
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        sync_q   <= 3'h0;
        stable_q <= 1'b0;
      end else begin
        sync_q <= {sync_q[1:0], port_din[p]};
        if (sync_q[2] == sync_q[1]) begin
          stable_q <= sync_q[2];
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        shift_q <= 8'h00;
        nbit_q  <= 3'h0;
        hold_q  <= 8'h00;
      end else if (div_q >= half && !clk_q) begin
        shift_q <= {shift_q[6:0], stable_q};
        nbit_q  <= nbit_q + 3'h1;
        if (nbit_q == 3'h7) begin
          hold_q <= {shift_q[6:0], stable_q};
        end
      end
    end

    assign port_clk[p]  = clk_q;
    assign port_byte[p] = hold_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shared_dcc_port_clock_o  <= 1'b0;
      shared_dcc_port_clock_oe <= 1'b0;
      line_dcc_port_clock_o    <= 1'b0;
      line_dcc_port_clock_oe   <= 1'b0;
    end else begin
      shared_dcc_port_clock_o  <= port_clk[0];
      shared_dcc_port_clock_oe <= g_port[0].oe_q;
      line_dcc_port_clock_o    <= port_clk[1];
      line_dcc_port_clock_oe   <= g_port[1].oe_q;
    end
  end

  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  toi_byte_s   f_byte;
  logic        f_valid;
  logic        pop;
  logic [3:0]  pos_row;
  logic [10:0] pos_col;
  logic [1:0]  tc;
  logic [3:0]  sts;
  toi_kind_e   kind;
  logic [7:0]  rei_val;
  logic [7:0]  ins_data;

  toi_fifo #(
    .WIDTH ($bits(toi_byte_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .wr_data  (in_byte),
    .wr_valid (in_valid),
    .wr_ready (in_ready),
    .rd_data  (f_byte),
    .rd_valid (f_valid),
    .rd_ready (!out_valid || out_ready)
  );

  assign pop     = f_valid && (!out_valid || out_ready);
  assign pos_row = f_byte.sof ? 4'h0 : row_q;
  assign pos_col = f_byte.sof ? 11'h000 : col_q;
  assign tc      = (pos_col < 11'd12) ? 2'h0 : (pos_col < 11'd24) ? 2'h1 : 2'h2;
  assign sts     = 4'(pos_col - 11'(tc) * 11'(`TOI_STS_N));
  assign kind    = (pos_col < 11'(`TOI_STS_N * `TOI_TOH_COLS)) ?
                   toh_kind(pos_row, tc, sts, master_q, cfg_q.growth_byte_definition) :
                   TK_PASS;

  // R14 block count limit
  // R15 bit count limit
  always_comb begin
    if (cfg_q.rei_block_mode) begin
      rei_val = (rx_oh.rei_count > REI_BLK_MAX) ? REI_BLK_MAX : rx_oh.rei_count;
    end else begin
      rei_val = (rx_oh.rei_count > REI_BIT_MAX) ? REI_BIT_MAX : rx_oh.rei_count;
    end
  end

  // R16 one source per byte
  // R17 framing, serial, register, received, pass
  always_comb begin
    ins_data = f_byte.data;
    case (kind)
      // R01 framing values
      TK_A1: ins_data = cfg_q.framing_insert_enable ? `TOI_A1_VALUE : f_byte.data;
      TK_A2: ins_data = cfg_q.framing_insert_enable ? `TOI_A2_VALUE : f_byte.data;
      TK_J0: begin
        // R05 path number pattern
        if (cfg_q.path_number_pattern_enable) begin
          ins_data = {4'h0, sts + 4'h1};
        // R06 trace into J0
        end else if (cfg_q.trace_insert_enable) begin
          ins_data = trace_byte;
        end
      end
      TK_Z0: begin
        if (cfg_q.path_number_pattern_enable) begin
          ins_data = {4'h0, sts + 4'h1};
        end
      end
      // R07 shared port section bytes
      TK_DSEC: begin
        if (cfg_q.shared_dcc_port_enable && !cfg_q.shared_dcc_channel_select) begin
          ins_data = port_byte[0];
        end
      end
      TK_DLINE: begin
        if (cfg_q.shared_dcc_port_enable && cfg_q.shared_dcc_channel_select) begin
          ins_data = port_byte[0];
        // R10 line port bytes
        end else if (cfg_q.line_dcc_port_enable) begin
          ins_data = port_byte[1];
        end
      end
      // R12 APS copy
      TK_K1: ins_data = cfg_q.protection_switch_insert_enable ? rx_oh.k1 : f_byte.data;
      TK_K2: ins_data = cfg_q.protection_switch_insert_enable ? rx_oh.k2 : f_byte.data;
      // R13 line REI into M1
      TK_M1: ins_data = cfg_q.line_rei_insert_enable ? rei_val : f_byte.data;
      default: ins_data = f_byte.data;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      row_q <= 4'h0;
      col_q <= 11'h000;
    end else if (pop) begin
      if (pos_col == COL_LAST) begin
        col_q <= 11'h000;
        row_q <= (pos_row == ROW_LAST) ? 4'h0 : pos_row + 4'h1;
      end else begin
        col_q <= pos_col + 11'h001;
        row_q <= pos_row;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_byte  <= '0;
      out_valid <= 1'b0;
    end else if (pop) begin
      out_byte  <= '{data: ins_data, sof: f_byte.sof};
      out_valid <= 1'b1;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  toi_kind_e  kind_q;
  logic       load_q;
  toi_cfg_s   cfg_at_q;
  logic [3:0] sts_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kind_q   <= TK_PASS;
      load_q   <= 1'b0;
      cfg_at_q <= '0;
      sts_q    <= 4'h0;
    end else begin
      kind_q   <= kind;
      load_q   <= pop;
      cfg_at_q <= cfg_q;
      sts_q    <= sts;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_loaded(toi_kind_e k);
    load_q && kind_q == k;
  endsequence

  a1_fixed_a: assert property (s_loaded(TK_A1) ##0 cfg_at_q.framing_insert_enable // R01
    |-> out_byte.data == `TOI_A1_VALUE) else $error("A1 not F6");
  a2_fixed_a: assert property (s_loaded(TK_A2) ##0 cfg_at_q.framing_insert_enable // R01
    |-> out_byte.data == `TOI_A2_VALUE) else $error("A2 not 28");
  z0_pattern_a: assert property (s_loaded(TK_Z0) ##0 cfg_at_q.path_number_pattern_enable // R05
    |-> out_byte.data == {4'h0, sts_q + 4'h1}) else $error("Z0 path number wrong");
  j0_trace_a: assert property (s_loaded(TK_J0) ##0 cfg_at_q.trace_insert_enable // R06
    && !cfg_at_q.path_number_pattern_enable |-> out_byte.data == $past(trace_byte))
    else $error("J0 trace not inserted");
  aps_copy_a: assert property (s_loaded(TK_K1) ##0 cfg_at_q.protection_switch_insert_enable // R12
    |-> out_byte.data == $past(rx_oh.k1)) else $error("K1 not copied");
  rei_block_a: assert property (s_loaded(TK_M1) ##0 cfg_at_q.line_rei_insert_enable // R14
    && cfg_at_q.rei_block_mode |-> out_byte.data <= REI_BLK_MAX) else $error("M1 over block max");
  rei_bit_a: assert property (s_loaded(TK_M1) ##0 cfg_at_q.line_rei_insert_enable // R15
    && !cfg_at_q.rei_block_mode |-> out_byte.data <= REI_BIT_MAX) else $error("M1 over bit max");
  shared_tristate_a: assert property (cfg_q.shared_dcc_clock_tristate [*2] // R09
    |=> !shared_dcc_port_clock_oe) else $error("shared clock driven");
  line_tristate_a: assert property (!cfg_q.line_dcc_clock_tristate [*2] // R11
    |=> line_dcc_port_clock_oe) else $error("line clock not driven");

endmodule : toi_inserter

// >>> testbench/toi_line_sink.sv
// line serializer model that takes the outgoing byte stream
`timescale 1ns/100ps

module toi_line_sink (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic hold,
  output logic      out_ready
);

  // ----------------------------------------------------------------
  // acceptance with random stalls
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || hold) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= ($urandom_range(15) != 0);
    end
  end

endmodule : toi_line_sink

// >>> testbench/test_transmit_overhead_inserter.sv
// self-checking bench of the transmit overhead inserter
`timescale 1ns/100ps
`include "toi_consts.svh"

module test_transmit_overhead_inserter import toi_pkg::*;;

  localparam logic [15:0] BASE = `TOI_CFG_CH2_OFFSET;
  localparam int          CEIL = 80000;
  localparam int          SEC_HALF = `TOI_CLK_HZ / (2 * `TOI_SEC_DCC_HZ);
  localparam int          LINE_HALF = `TOI_CLK_HZ / (2 * `TOI_LINE_DCC_HZ);

  logic        clk, rst_n, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  toi_byte_s   in_byte, out_byte;
  toi_rx_oh_s  rx_oh;
  logic [7:0]  trace_byte;
  logic        sh_ser, ln_ser, sh_clk, sh_oe, ln_clk, ln_oe, hold, master, dcc_ok;
  logic [11:0] cfg;
  logic [9:0]  expq[$];
  logic [9:0]  e;
  int          bad_count, tests_run, cycles;

  toi_inserter #(.CHANNEL(2), .FIFO_DEPTH(16)) toi_inserter_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_byte(in_byte),
    .in_valid(in_valid), .in_ready(in_ready), .out_byte(out_byte),
    .out_valid(out_valid), .out_ready(out_ready), .trace_byte(trace_byte),
    .rx_oh(rx_oh), .shared_dcc_serial_port(sh_ser), .shared_dcc_port_clock_o(sh_clk),
    .shared_dcc_port_clock_oe(sh_oe), .line_dcc_serial_port(ln_ser),
    .line_dcc_port_clock_o(ln_clk), .line_dcc_port_clock_oe(ln_oe));

  toi_line_sink toi_line_sink_i (
    .clk(clk), .rst_n(rst_n), .hold(hold), .out_ready(out_ready));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check(reg_rdata, exp);
  endtask : rd

  // expected outgoing byte: {skip, data, sof}
  function automatic logic [9:0] exp_byte(logic [7:0] d, int row, int col);
    int         t, s;
    logic [7:0] v, r;
    logic       skip;
    t = col / 12;
    s = col % 12;
    v = d;
    r = rx_oh.rei_count;
    skip = 1'b0;
    if (col < 36) begin
      if (row == 0 && t == 0 && cfg[0]) v = `TOI_A1_VALUE;
      if (row == 0 && t == 1 && cfg[0]) v = `TOI_A2_VALUE;
      if (row == 0 && t == 2) begin
        if (master && s == 0) begin
          if (cfg[2]) v = 8'h01;
          else if (cfg[3]) v = trace_byte;
        end else if (s <= (cfg[1] ? `TOI_Z0_ITU_LAST : `TOI_Z0_WIDE_LAST) && cfg[2]) begin
          v = 8'(s + 1);
        end
      end
      if (row == 2 && s == 0 && cfg[4] && !cfg[6]) begin
        v = 8'hFF;
        skip = !dcc_ok;
      end
      if (row >= 5 && row <= 7 && s == 0) begin
        if (cfg[4] && cfg[6]) begin
          v = 8'hFF;
          skip = !dcc_ok;
        end else if (cfg[7]) begin
          v = 8'h00;
          skip = !dcc_ok;
        end
      end
      if (row == 4 && s == 0 && t == 1 && cfg[9]) v = rx_oh.k1;
      if (row == 4 && s == 0 && t == 2 && cfg[9]) v = rx_oh.k2;
      if (row == 8 && col == 14 && cfg[10]) begin
        if (cfg[11]) v = (r > 8'h04) ? 8'h04 : r;
        else v = (r > 8'h60) ? 8'h60 : r;
      end
    end
    return {skip, v, (row == 0 && col == 0)};
  endfunction : exp_byte

  task automatic send_frame();
    toi_byte_s b;
    trace_byte <= 8'($urandom);
    rx_oh      <= 24'($urandom);
    for (int row = 0; row < 9; row++) begin
      for (int col = 0; col < `TOI_COL_N; col++) begin
        b.data = 8'($urandom);
        b.sof  = (row == 0 && col == 0);
        in_byte  <= b;
        in_valid <= 1'b1;
        @(posedge clk);
        while (!in_ready) @(posedge clk);
        expq.push_back(exp_byte(b.data, row, col));
      end
    end
    in_valid <= 1'b0;
    @(posedge clk);
  endtask : send_frame

  task automatic drain();
    int n;
    n = 0;
    while (expq.size() != 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check(16'(expq.size()), 16'h0000);
  endtask : drain

  task automatic clk_half(input bit ln, input int exp);
    int   n;
    logic v;
    for (int k = 0; k < 2; k++) begin
      v = ln ? ln_clk : sh_clk;
      n = 0;
      while ((ln ? ln_clk : sh_clk) === v && n < 2000) begin
        @(posedge clk);
        n++;
      end
    end
    check(16'(n), 16'(exp));
  endtask : clk_half

  task automatic set_cfg(input logic [11:0] c, input logic m);
    drain();
    cfg = c;
    master = m;
    dcc_ok = 1'b0;
    wr(BASE, {4'h0, c});
    wr(BASE + `TOI_AUX_DELTA, {15'h0000, m});
    repeat (2) @(posedge clk);
    check({14'h0000, sh_oe, ln_oe}, {14'h0000, ~c[5], ~c[8]});
  endtask : set_cfg

  // ----------------------------------------------------------------
  // clock, timeout and output monitor
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == CEIL) begin
      bad_count++;
      test_done();
    end
  end

  always @(posedge clk) begin
    if (rst_n && out_valid && out_ready) begin
      if (expq.size() == 0) begin
        check(16'(out_byte), 16'hFFFF);
      end else begin
        e = expq.pop_front();
        if (!e[9]) check(16'(out_byte), 16'(e[8:0]));
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hFD50));
    rst_n = 1'b0;
    {reg_wr, reg_rd, in_valid} = 3'b000;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    in_byte = '0;
    rx_oh = '0;
    trace_byte = 8'h00;
    sh_ser = 1'b1;
    ln_ser = 1'b0;
    hold = 1'b1;
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    cfg = `TOI_CFG_RESET;
    master = 1'b1;
    dcc_ok = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(BASE, 16'h0721);
    rd(BASE + `TOI_AUX_DELTA, 16'h0001);
    check({14'h0000, sh_oe, ln_oe}, 16'h0000);
    wr(`TOI_CFG_CH1_OFFSET, 16'hFFFF);
    rd(`TOI_CFG_CH1_OFFSET, 16'h0000);
    wr(BASE, 16'hFFFF);
    rd(BASE, 16'h0FFF);
    wr(BASE, 16'h0721);
    // fill the fifo with the sink stalled, then let it drain
    fork
      send_frame();
      begin
        repeat (100) @(posedge clk);
        check({15'h0000, in_ready}, 16'h0000);
        check(16'((expq.size() == 16) || (expq.size() == 17)), 16'h0001);
        // one byte taken into the output stage: next position is column 1
        rd(BASE + `TOI_STAT_DELTA, 16'h0010);
        hold <= 1'b0;
      end
    join
    // narrow growth with national bytes left as random data
    set_cfg(12'hCDE, 1'b0);
    clk_half(1'b0, LINE_HALF);
    send_frame();
    dcc_ok = 1'b1;
    send_frame();
    set_cfg(12'hE99, 1'b1);
    clk_half(1'b0, SEC_HALF);
    clk_half(1'b1, LINE_HALF);
    send_frame();
    dcc_ok = 1'b1;
    send_frame();
    drain();
    test_done();
  end

endmodule : test_transmit_overhead_inserter
